// >>> rtl/qfp_pipeline.v
// Quad-phase fetch/execute pipeline sequencer for a 14-bit instruction core.
// Assumes synchronous program memory data valid by phase four, and an
// execute unit that decodes instr_hold_reg and reports branches/results.
// Function
// - Four phases from oscillator, one cycle each
// - Program counter increments at phase one
// - Capture fetched word by phase four
// - Load instruction register at phase one
// - Fetch overlaps execute, one per cycle
// - Counter-altering instructions take two cycles
// - Branch flushes fetched word, refetches target
// - Operand read phase two, write phase four
// - Thirteen-bit counter, 8K by 14 space
// - Addresses wrap within implemented space
// - Fetch starts at address zero after reset
// - Interrupt redirects fetch to address four
`timescale 1ns/1ns
`include "qfp_defs.vh"

module qfp_pipeline #(
  parameter MEM_WORDS = `QFP_MEM_WORDS
) (
  // Clock and reset; clock_i is the oscillator input
  input wire clock_i,
  input wire arst_n_i,
  // Program memory
  output reg [`QFP_PC_W-1:0] prog_addr_o,
  input wire [`QFP_WORD_W-1:0] prog_data_i,
  // Execute unit requests, sampled at phase four of the execution cycle
  input wire branch_i,
  input wire [`QFP_PC_W-1:0] branch_target_i,
  input wire int_accept_i,
  // Instruction to execute and phase strobes
  output reg [`QFP_WORD_W-1:0] instr_hold_reg_o,
  output reg instr_valid_o,
  output reg [`QFP_PC_W-1:0] prog_counter_o,
  output wire phase_one_o,
  output wire phase_two_o,
  output wire phase_three_o,
  output wire phase_four_o,
  // Data memory strobes
  output wire data_rd_o,
  output wire data_wr_o
);

  // keep the counter inside the implemented space
  localparam [`QFP_PC_W-1:0] ADDR_MASK = (MEM_WORDS >= 8192) ? 13'h1fff :
                                          (MEM_WORDS >= 4096) ? 13'h0fff :
                                          (MEM_WORDS >= 2048) ? 13'h07ff : 13'h03ff;

  // Phase sequencer states, in the order they run
  localparam [`QFP_PHASE_W-1:0] ST_ONE = `QFP_PH_ONE;
  localparam [`QFP_PHASE_W-1:0] ST_TWO = `QFP_PH_TWO;
  localparam [`QFP_PHASE_W-1:0] ST_THREE = `QFP_PH_THREE;
  localparam [`QFP_PHASE_W-1:0] ST_FOUR = `QFP_PH_FOUR;
  localparam [`QFP_PC_W-1:0] PC_STEP = 13'h0001;

  // Phase sequencer
  reg [`QFP_PHASE_W-1:0] phase_q;
  reg [`QFP_PHASE_W-1:0] phase_d;
  // Fetch stage
  reg [`QFP_PC_W-1:0] pc_d;
  reg [`QFP_WORD_W-1:0] fetch_word_q;
  reg [`QFP_WORD_W-1:0] fetch_word_d;
  reg fetch_valid_q;
  reg fetch_valid_d;
  // Set by reset until the first fetch address is issued
  reg start_q;
  reg start_d;
  // Execute stage; next values of the output registers
  reg [`QFP_WORD_W-1:0] hold_d;
  reg exec_valid_d;
  // Redirect requests and candidate addresses
  wire exec_close;
  wire take_int;
  wire take_branch;
  wire redirect;
  wire [`QFP_PC_W-1:0] redirect_addr;
  wire [`QFP_PC_W-1:0] seq_addr;
  wire [`QFP_PC_W-1:0] reset_addr;

  // Free-running sequencer: one instruction cycle is four clocks
  always @* begin
    case (phase_q)
      ST_ONE: begin
        phase_d = ST_TWO;
      end
      ST_TWO: begin
        phase_d = ST_THREE;
      end
      ST_THREE: begin
        phase_d = ST_FOUR;
      end
      default: begin
        phase_d = ST_ONE;
      end
    endcase
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Start in phase four so the first edge issues the reset vector
      phase_q <= ST_FOUR;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Phase decode; exactly one strobe is high in any clock
  assign phase_one_o = (phase_q == ST_ONE);
  assign phase_two_o = (phase_q == ST_TWO);
  assign phase_three_o = (phase_q == ST_THREE);
  assign phase_four_o = (phase_q == ST_FOUR);

  // A request in a bubble cycle is ignored; the execute unit must hold it
  // until a valid instruction closes its cycle. Interrupt wins over branch.
  assign exec_close = phase_four_o & instr_valid_o;
  assign take_int = exec_close & int_accept_i;
  assign take_branch = exec_close & branch_i & ~int_accept_i;
  assign redirect = take_int | take_branch;
  // Targets above the implemented space are folded by the mask below
  assign redirect_addr = take_int ? `QFP_INT_VEC : branch_target_i;
  assign seq_addr = prog_counter_o + PC_STEP;
  assign reset_addr = `QFP_RESET_VEC;

  // Next fetch address, issued as phase one begins
  always @* begin
    pc_d = prog_counter_o;
    if (phase_four_o) begin
      if (start_q) begin
        pc_d = reset_addr & ADDR_MASK;
      end else if (redirect) begin
        // Target goes out at once, so only one fetch slot is lost
        pc_d = redirect_addr & ADDR_MASK;
      end else begin
        // Steps past the top implemented word back to zero
        pc_d = seq_addr & ADDR_MASK;
      end
    end
  end

  // Program counter and memory address are twin registers
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Issued again on the first edge after release
      prog_counter_o <= `QFP_RESET_VEC;
      prog_addr_o <= `QFP_RESET_VEC;
    end else begin
      prog_counter_o <= pc_d;
      prog_addr_o <= pc_d;
    end
  end

  // Reset-vector request, cleared once the first address is issued
  always @* begin
    start_d = start_q;
    if (phase_four_o) begin
      start_d = 1'b0;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_q <= 1'b1;
    end else begin
      start_q <= start_d;
    end
  end

  // Fetch capture at the edge closing phase three
  always @* begin
    fetch_word_d = fetch_word_q;
    fetch_valid_d = fetch_valid_q;
    if (phase_three_o) begin
      fetch_word_d = prog_data_i;
      // A word read before the reset vector went out is not real
      fetch_valid_d = ~start_q;
    end
    if (redirect) begin
      // The sequential word fetched beside a branch is never executed
      fetch_valid_d = 1'b0;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Bubble until the first real word is captured
      fetch_word_q <= `QFP_NOP_WORD;
      fetch_valid_q <= 1'b0;
    end else begin
      fetch_word_q <= fetch_word_d;
      fetch_valid_q <= fetch_valid_d;
    end
  end

  // Execute stage: the fetched word moves in as phase one begins
  always @* begin
    hold_d = instr_hold_reg_o;
    exec_valid_d = instr_valid_o;
    if (phase_four_o) begin
      hold_d = fetch_word_q;
      // A taken branch leaves a bubble while its target is fetched
      exec_valid_d = fetch_valid_q & ~redirect;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Execute bubbles until the first word arrives
      instr_hold_reg_o <= `QFP_NOP_WORD;
      instr_valid_o <= 1'b0;
    end else begin
      instr_hold_reg_o <= hold_d;
      instr_valid_o <= exec_valid_d;
    end
  end

  // Data strobes only during an execution cycle that holds a real instruction
  // Strobes are decoded, not registered, so they track the phase with no lag
  assign data_rd_o = phase_two_o & instr_valid_o;
  assign data_wr_o = phase_four_o & instr_valid_o;

endmodule // qfp_pipeline

// >>> shared/qfp_defs.vh
// Constants for the quad-phase fetch pipeline controller.
// Assumes inclusion by the controller module only.
`ifndef QFP_DEFS_VH
`define QFP_DEFS_VH

`define QFP_PC_W 13
`define QFP_WORD_W 14
`define QFP_DADDR_W 7
`define QFP_DATA_W 8
`define QFP_RESET_VEC 13'h0000
`define QFP_INT_VEC 13'h0004
`define QFP_NOP_WORD 14'h0000
`define QFP_PHASE_W 2
`define QFP_PH_ONE 2'h0
`define QFP_PH_TWO 2'h1
`define QFP_PH_THREE 2'h2
`define QFP_PH_FOUR 2'h3
// Implemented program size in words: 1024, 2048, 4096 or 8192
`define QFP_MEM_WORDS 8192

`endif

// >>> sim/qfp_monitor.sv
// Checker for the quad-phase sequencer; bound onto every qfp_pipeline.
`timescale 1ns/1ns
module qfp_monitor #(parameter MEM_WORDS = 8192) (
  input wire logic clock_i, arst_n_i, branch_i, int_accept_i, instr_valid_o, data_rd_o, data_wr_o,
  input wire logic phase_one_o, phase_two_o, phase_three_o, phase_four_o,
  input wire logic [12:0] prog_addr_o, branch_target_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_mid; phase_two_o ##1 phase_three_o ##1 phase_four_o; endsequence
  wire x4 = phase_four_o && instr_valid_o;
  phase_hot_a: assert property (
    $onehot({phase_one_o, phase_two_o, phase_three_o, phase_four_o})) else $error("hot");
  phase_order_a: assert property (phase_one_o |=> s_mid ##1 phase_one_o) else $error("order");
  addr_hold_a: assert property (!phase_one_o |-> $stable(prog_addr_o)) else $error("hold");
  seq_step_a: assert property (x4 && !branch_i && !int_accept_i |=>
    prog_addr_o == (($past(prog_addr_o) + 13'h1) & 13'(MEM_WORDS - 1))) else $error("step");
  branch_go_a: assert property (x4 && branch_i && !int_accept_i |=>
    !instr_valid_o && prog_addr_o == ($past(branch_target_i) & 13'(MEM_WORDS - 1))) else $error("branch");
  int_vec_a: assert property (x4 && int_accept_i |=>
    !instr_valid_o && prog_addr_o == 13'h0004) else $error("int");
  data_rd_a: assert property (data_rd_o == (phase_two_o && instr_valid_o)) else $error("rd");
  data_wr_a: assert property (data_wr_o == (phase_four_o && instr_valid_o)) else $error("wr");
endmodule // qfp_monitor
bind qfp_pipeline qfp_monitor #(.MEM_WORDS(MEM_WORDS)) mon_u (.*);

// >>> sim/qfp_prog_mem.sv
// Program memory model; word is the address with the top bit set.
`timescale 1ns/1ns
module qfp_prog_mem (
  input wire logic [12:0] addr_i,
  output wire logic [13:0] data_o);
  assign data_o = {1'b1, addr_i};
endmodule // qfp_prog_mem

// >>> sim/tb.sv
// Bench for the quad-phase sequencer; inputs change at the falling edge.
`timescale 1ns/1ns
module tb;
  logic clock_i = 0, arst_n_i = 0, branch_i = 0, int_accept_i = 0, instr_valid_o, data_rd_o, data_wr_o;
  logic phase_one_o, phase_two_o, phase_three_o, phase_four_o;
  logic [12:0] branch_target_i = 0, prog_addr_o, prog_counter_o;
  logic [13:0] prog_data_i, instr_hold_reg_o;
  int err_count = 0, checks_done = 0, cyc = 0;
  qfp_pipeline #(.MEM_WORDS(1024)) dut_u (.*);
  qfp_prog_mem mem_u (.addr_i(prog_addr_o), .data_o(prog_data_i));
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (++cyc > 300) begin err_count++; end_sim; end
  task end_sim;
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(string n, logic [13:0] e, s);
    checks_done++;
    if (s !== e) begin err_count++; $display("wrong value %s exp %h got %h", n, e, s); end
  endtask
  task ph(logic one);
    do @(negedge clock_i); while (one ? !phase_one_o : !phase_four_o);
  endtask
  task t_start;
    ph(1);
    chk("valid", 0, instr_valid_o);
    ph(1);
    chk("instr", 14'h2000, instr_hold_reg_o);
    ph(0);
    chk("wr", 1, data_wr_o);
    ph(1);
    chk("instr", 14'h2001, instr_hold_reg_o);
    chk("pc", 14'h0002, prog_counter_o);
  endtask
  // Branch target at the top word, so with irq clear the next fetch must wrap
  task t_jump(logic irq, logic [13:0] w, w2);
    ph(0);
    branch_i = 1; int_accept_i = irq; branch_target_i = 13'h03ff;
    ph(1);
    branch_i = 0; int_accept_i = 0;
    chk("valid", 0, instr_valid_o);
    chk("pc", {1'b0, w[12:0]}, prog_counter_o);
    ph(0);
    chk("wr", 0, data_wr_o);
    ph(1);
    chk("instr", w, instr_hold_reg_o);
    ph(1);
    chk("instr", w2, instr_hold_reg_o);
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    arst_n_i = 1;
    t_start;
    t_jump(0, 14'h23ff, 14'h2000);
    t_jump(1, 14'h2004, 14'h2005);
    end_sim;
  end
endmodule // tb
